// file: design/nim_strap_config_logic.sv
`timescale 1ns/1ps
module nim_strap_config_logic import nim_cfg_pkg::*; #(
  parameter int RESET_CYCLES = RESET_C,
  parameter int RECON_LONG = RECON_LONG_C,
  parameter int RECON_SHORT = RECON_SHORT_C
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic timeout_select_hi,
  input wire logic timeout_select_lo,
  input wire logic boot_memory_enable,
  input wire logic [7:0] node_address_switch,
  input wire logic irq_event,
  input wire logic rx_active,
  output logic [IRQ_LINES-1:0] irq_lines,
  output logic led_yellow,
  output logic led_green,
  output logic tx_enable,
  output logic [21:0] response_cycles,
  output logic [21:0] idle_cycles,
  output logic [27:0] recon_cycles,
  output logic [13:0] mem_window_size
);

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [1:0] timeout_sel(input logic hi, input logic lo);
    timeout_sel = {hi, lo};
  endfunction

  logic [1:0] tsel;
  logic [7:0] node_q;
  logic sw_node_q;
  logic [7:0] node_sw;
  logic [7:0] node_eff;
  logic [2:0] irq_sel_q;
  logic [BUF_AW-1:0] buf_addr_q;
  logic [7:0] buf_mem [0:(1<<BUF_AW)-1];
  logic [7:0] buf_rd_q;
  logic [31:0] rst_cnt_q;
  init_e init_q;
  logic busy_q;
  logic [7:0] yel_cnt_q;

  // Switch bit 0 is position 1 (MSB); open switch already reads one
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      node_sw[7-i] = node_address_switch[i];
    end
  end
  assign node_eff = sw_node_q ? node_q : node_sw;
  assign tsel = timeout_sel(timeout_select_hi, timeout_select_lo);

  ////////////////////////////////////////////////////////////////////////////
  // Timeout selection
  always_ff @(posedge clk) begin
    if (reset) begin
      response_cycles <= 22'h0;
      idle_cycles <= 22'h0;
      recon_cycles <= 28'h0;
    end else begin
      case (tsel)
        2'b00: begin
          response_cycles <= 22'(RESP_C0);
          idle_cycles <= 22'(IDLE_C0);
          recon_cycles <= 28'(RECON_LONG);
        end
        2'b01: begin
          response_cycles <= 22'(RESP_C1);
          idle_cycles <= 22'(IDLE_C1);
          recon_cycles <= 28'(RECON_LONG);
        end
        2'b10: begin
          response_cycles <= 22'(RESP_C2);
          idle_cycles <= 22'(IDLE_C2);
          recon_cycles <= 28'(RECON_LONG);
        end
        default: begin
          response_cycles <= 22'(RESP_C3);
          idle_cycles <= 22'(IDLE_C3);
          recon_cycles <= 28'(RECON_SHORT);
        end
      endcase
    end
  end

  // Memory window: buffer only, or whole 16K segment with boot memory
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_window_size <= 14'h0;
    end else if (boot_memory_enable) begin
      mem_window_size <= 14'h3fff;
    end else begin
      mem_window_size <= 14'((1 << BUF_AW) - 1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Internal reset time, then signature and node address into buffer
  always_ff @(posedge clk) begin
    if (reset) begin
      init_q <= INIT_WAIT;
      rst_cnt_q <= 32'h0;
    end else begin
      case (init_q)
        INIT_WAIT: begin
          if (rst_cnt_q >= 32'(RESET_CYCLES - 1)) begin
            init_q <= INIT_SIG;
          end else begin
            rst_cnt_q <= rst_cnt_q + 32'h1;
          end
        end
        INIT_SIG: init_q <= INIT_NODE;
        INIT_NODE: init_q <= INIT_DONE;
        default: init_q <= INIT_DONE;
      endcase
    end
  end

  // Transmitter held off until init done and address nonzero
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_enable <= 1'b0;
    end else begin
      tx_enable <= (init_q == INIT_DONE) && (node_eff != 8'h00);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave: one wait cycle per access, answer on the second cycle
  logic req;
  logic buf_ok;
  logic wr_take;
  assign req = avs_read | avs_write;
  assign buf_ok = (node_eff != 8'h00);
  assign wr_take = avs_write && busy_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      busy_q <= 1'b0;
      avs_waitrequest <= 1'b1;
    end else begin
      busy_q <= req && !busy_q;
      avs_waitrequest <= !(req && !busy_q);
    end
  end

  always_ff @(posedge clk) begin
    if (init_q == INIT_SIG) begin
      buf_mem[BUF_AW'(BUF_SIG_ADDR)] <= BUF_SIGNATURE;
    end else if (init_q == INIT_NODE) begin
      buf_mem[BUF_AW'(BUF_NODE_ADDR)] <= node_eff;
    end else if (wr_take && avs_address == REG_BUF_DATA && buf_ok) begin
      buf_mem[buf_addr_q] <= avs_writedata[7:0];
    end
  end

  always_ff @(posedge clk) begin
    buf_rd_q <= buf_mem[buf_addr_q];
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      node_q <= 8'h00;
      sw_node_q <= 1'b0;
      irq_sel_q <= IRQ_DEFAULT;
      buf_addr_q <= '0;
    end else if (wr_take) begin
      if (avs_address == REG_NODE) begin
        node_q <= avs_writedata[7:0];
        sw_node_q <= 1'b1;
      end else if (avs_address == REG_BUF_ADDR) begin
        buf_addr_q <= avs_writedata[BUF_AW-1:0];
      end else if (avs_address == REG_IRQ_SEL) begin
        if (avs_writedata[2:0] < 3'(IRQ_LINES)) begin
          irq_sel_q <= avs_writedata[2:0];
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !busy_q) begin
      if (avs_address == REG_STATUS) begin
        avs_readdata <= 32'h0;
        avs_readdata[STAT_SEL_HI] <= timeout_select_hi;
        avs_readdata[STAT_SEL_LO] <= timeout_select_lo;
        avs_readdata[STAT_NODE_OK] <= buf_ok;
        avs_readdata[STAT_TX_EN] <= tx_enable;
        avs_readdata[STAT_BOOT] <= boot_memory_enable;
        avs_readdata[STAT_INIT_DONE] <= (init_q == INIT_DONE);
      end else if (avs_address == REG_CONTROL) begin
        avs_readdata <= {31'h0, rx_active};
      end else if (avs_address == REG_NODE) begin
        avs_readdata <= {24'h0, node_eff};
      end else if (avs_address == REG_TIMING) begin
        avs_readdata <= {30'h0, tsel};
      end else if (avs_address == REG_BUF_ADDR) begin
        avs_readdata <= {21'h0, buf_addr_q};
      end else if (avs_address == REG_BUF_DATA) begin
        avs_readdata <= buf_ok ? {24'h0, buf_rd_q} : 32'h0;
      end else if (avs_address == REG_IRQ_SEL) begin
        avs_readdata <= {29'h0, irq_sel_q};
      end else if (avs_address == REG_MEM_SIZE) begin
        avs_readdata <= {18'h0, mem_window_size};
      end else begin
        avs_readdata <= 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt onto exactly one line
  always_ff @(posedge clk) begin
    if (reset) begin
      irq_lines <= '0;
    end else begin
      for (int i = 0; i < IRQ_LINES; i++) begin
        irq_lines[i] <= irq_event && (irq_sel_q == 3'(i));
      end
    end
  end

  // Yellow stretched so a single access is visible
  always_ff @(posedge clk) begin
    if (reset) begin
      yel_cnt_q <= 8'h0;
      led_yellow <= 1'b0;
    end else begin
      if (req) begin
        yel_cnt_q <= 8'hff;
      end else if (yel_cnt_q != 8'h0) begin
        yel_cnt_q <= yel_cnt_q - 8'h1;
      end
      led_yellow <= req || (yel_cnt_q != 8'h0);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      led_green <= 1'b0;
    end else begin
      led_green <= rx_active;
    end
  end

endmodule

// file: design/nim_cfg_pkg.sv
// Notes on behaviour
// - Timeout straps shown as status bits 6, 5
// - Four response times from strap pattern
// - Selection also sets idle and reconfig times
// - No boot strap: decode only buffer memory
// - Interrupt on one of five lines, IRQ7 default
// - Yellow light on host I/O access
// - Green light while receiving network traffic
// - 8-bit switch; nonzero value is valid address
// - Zero address: transmitter off, stay offline
// - Zero address: refuse host buffer access
// - Position 1 is MSB; open reads one
// - After reset write d1 then node address
package nim_cfg_pkg;
  localparam int CLK_MHZ = 25;
  localparam logic [3:0] REG_STATUS = 4'h0;
  localparam logic [3:0] REG_CONTROL = 4'h1;
  localparam logic [3:0] REG_NODE = 4'h2;
  localparam logic [3:0] REG_TIMING = 4'h3;
  localparam logic [3:0] REG_BUF_ADDR = 4'h4;
  localparam logic [3:0] REG_BUF_DATA = 4'h5;
  localparam logic [3:0] REG_IRQ_SEL = 4'h6;
  localparam logic [3:0] REG_MEM_SIZE = 4'h7;
  localparam int STAT_SEL_HI = 6;
  localparam int STAT_SEL_LO = 5;
  localparam int STAT_NODE_OK = 0;
  localparam int STAT_TX_EN = 1;
  localparam int STAT_BOOT = 2;
  localparam int STAT_INIT_DONE = 3;
  localparam int CTRL_RX_ACT = 0;
  localparam logic [7:0] BUF_SIG_ADDR = 8'h00;
  localparam logic [7:0] BUF_NODE_ADDR = 8'h01;
  localparam logic [7:0] BUF_SIGNATURE = 8'hd1;
  localparam logic [2:0] IRQ_DEFAULT = 3'h4;
  localparam int IRQ_LINES = 5;
  // Times in tenths of a microsecond and in milliseconds
  localparam int RESP_T0_US10 = 12096;
  localparam int RESP_T1_US10 = 6048;
  localparam int RESP_T2_US10 = 3024;
  localparam int RESP_T3_US10 = 756;
  localparam int IDLE_T0_US10 = 13184;
  localparam int IDLE_T1_US10 = 6592;
  localparam int IDLE_T2_US10 = 3296;
  localparam int IDLE_T3_US10 = 824;
  localparam int RECON_LONG_MS = 1680;
  localparam int RECON_SHORT_MS = 840;
  localparam int RESET_T_US10 = 1024;
  localparam int RESP_C0 = RESP_T0_US10 * CLK_MHZ / 10;
  localparam int RESP_C1 = RESP_T1_US10 * CLK_MHZ / 10;
  localparam int RESP_C2 = RESP_T2_US10 * CLK_MHZ / 10;
  localparam int RESP_C3 = RESP_T3_US10 * CLK_MHZ / 10;
  localparam int IDLE_C0 = IDLE_T0_US10 * CLK_MHZ / 10;
  localparam int IDLE_C1 = IDLE_T1_US10 * CLK_MHZ / 10;
  localparam int IDLE_C2 = IDLE_T2_US10 * CLK_MHZ / 10;
  localparam int IDLE_C3 = IDLE_T3_US10 * CLK_MHZ / 10;
  localparam int RECON_LONG_C = RECON_LONG_MS * CLK_MHZ * 1000;
  localparam int RECON_SHORT_C = RECON_SHORT_MS * CLK_MHZ * 1000;
  localparam int RESET_C = (RESET_T_US10 * CLK_MHZ + 9) / 10;
  localparam int BUF_AW = 11;
  localparam int BOOT_AW = 13;
  typedef enum logic [3:0] {
    INIT_WAIT = 4'b0001,
    INIT_SIG = 4'b0010,
    INIT_NODE = 4'b0100,
    INIT_DONE = 4'b1000
  } init_e;
endpackage

// file: verif/nim_cfg_monitor.sv
`timescale 1ns/1ps
module nim_cfg_monitor import nim_cfg_pkg::*; #(
  parameter int RECON_SHORT = 50
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic avs_waitrequest,
  input wire logic timeout_select_hi,
  input wire logic timeout_select_lo,
  input wire logic boot_memory_enable,
  input wire logic irq_event,
  input wire logic rx_active,
  input wire logic [IRQ_LINES-1:0] irq_lines,
  input wire logic led_yellow,
  input wire logic led_green,
  input wire logic tx_enable,
  input wire logic [21:0] response_cycles,
  input wire logic [27:0] recon_cycles,
  input wire logic [13:0] mem_window_size
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  chk_wait_answer: assert property ((avs_read || avs_write) &&
    avs_waitrequest |=> !avs_waitrequest) else $error("no answer");
  chk_wait_single: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("answer too long");
  chk_yellow_lit: assert property (
    (avs_read || avs_write) |=> led_yellow) else $error("yellow dark");
  chk_green_follows: assert property (
    !$past(reset) |-> led_green == $past(rx_active)) else $error("green");
  chk_irq_onehot: assert property ($onehot0(irq_lines))
    else $error("irq lines");
  chk_irq_quiet: assert property (
    !$past(irq_event) && !$past(reset) |-> irq_lines == '0)
    else $error("irq without event");
  chk_reset_state: assert property ($past(reset) |->
    avs_waitrequest && !tx_enable && !led_yellow) else $error("reset state");
  chk_mem_window: assert property (!$past(reset) |->
    mem_window_size == ($past(boot_memory_enable) ? 14'h3fff : 14'h07ff))
    else $error("window size");
  chk_short_timing: assert property (!$past(reset) &&
    $past(timeout_select_hi && timeout_select_lo) |->
    response_cycles == 22'(RESP_C3) && recon_cycles == 28'(RECON_SHORT))
    else $error("short timing");
  cover property (avs_read && !avs_waitrequest);
  cover property ($rose(led_green));
  cover property (irq_lines[4]);
endmodule

bind nim_strap_config_logic nim_cfg_monitor #(.RECON_SHORT(RECON_SHORT))
  u_nim_cfg_monitor (.clk(clk), .reset(reset), .avs_read(avs_read),
  .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
  .timeout_select_hi(timeout_select_hi),
  .timeout_select_lo(timeout_select_lo),
  .boot_memory_enable(boot_memory_enable), .irq_event(irq_event),
  .rx_active(rx_active), .irq_lines(irq_lines), .led_yellow(led_yellow),
  .led_green(led_green), .tx_enable(tx_enable),
  .response_cycles(response_cycles), .recon_cycles(recon_cycles),
  .mem_window_size(mem_window_size));

// file: verif/net_rx_peer.sv
`timescale 1ns/1ps
module net_rx_peer #(
  parameter int LEN = 10
) (
  input wire logic clk,
  input wire logic start,
  output logic rx_active
);
  int cnt = 0;
  // Receive burst of LEN cycles, quiet otherwise
  always @(posedge clk) begin
    if (start) begin
      cnt <= LEN;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
    end
  end
  assign rx_active = cnt > 0;
endmodule

// file: verif/nim_strap_config_logic_tb_top.sv
`timescale 1ns/1ps
module nim_strap_config_logic_tb_top import nim_cfg_pkg::*;;
  logic clk = 0, reset = 1, avs_read = 0, avs_write = 0;
  logic hi = 0, lo = 0, boot = 0, irq_event = 0, start = 0;
  logic [3:0] avs_address = '0;
  logic [31:0] avs_writedata = '0, avs_readdata;
  logic avs_waitrequest, led_yellow, led_green, tx_enable, rx_active;
  logic [7:0] sw = 8'h01, node;
  logic [IRQ_LINES-1:0] irq_lines;
  logic [21:0] response_cycles, idle_cycles;
  logic [27:0] recon_cycles;
  logic [13:0] mem_window_size;
  logic [31:0] exp_q[$], mask_q[$];
  int errors = 0, samples_checked = 0, seed = 32'h621f;
  int resp_t[4] = '{RESP_C0, RESP_C1, RESP_C2, RESP_C3};
  int idle_t[4] = '{IDLE_C0, IDLE_C1, IDLE_C2, IDLE_C3};
  nim_strap_config_logic #(.RESET_CYCLES(8), .RECON_LONG(100),
    .RECON_SHORT(50)) u_nim_strap_config_logic (.clk(clk), .reset(reset),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .timeout_select_hi(hi),
    .timeout_select_lo(lo), .boot_memory_enable(boot),
    .node_address_switch(sw), .irq_event(irq_event), .rx_active(rx_active),
    .irq_lines(irq_lines), .led_yellow(led_yellow), .led_green(led_green),
    .tx_enable(tx_enable), .response_cycles(response_cycles),
    .idle_cycles(idle_cycles), .recon_cycles(recon_cycles),
    .mem_window_size(mem_window_size));
  net_rx_peer u_net_rx_peer (.clk(clk), .start(start),
    .rx_active(rx_active));
  always #20 clk = ~clk;
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task give_verdict;
    if (errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    @(posedge clk);
    while (avs_waitrequest) @(posedge clk);
    avs_read <= 0;
    avs_write <= 0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    bus(0, a, 0);
  endtask
  always @(posedge clk) begin
    if (avs_read && !avs_waitrequest) begin
      check(avs_readdata & mask_q.pop_front(), exp_q.pop_front());
    end
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    give_verdict;
  end
  initial begin
    sw = $random(seed);
    if (sw == 0) sw = 8'ha0;
    node = {<<{sw}};
    repeat (4) @(posedge clk);
    reset <= 0;
    for (int n = 0; n < 40 && tx_enable !== 1; n++) @(posedge clk);
    check(tx_enable, 1);
    rd(REG_IRQ_SEL, 4, 'h7);
    rd(REG_NODE, node, 'hff);
    bus(1, REG_BUF_ADDR, 0);
    rd(REG_BUF_DATA, 'hd1, 'hff);
    bus(1, REG_BUF_ADDR, 1);
    rd(REG_BUF_DATA, node, 'hff);
    check(led_yellow, 1);
    for (int i = 0; i < 4; i++) begin
      hi <= i[1];
      lo <= i[0];
      boot <= i[0];
      repeat (3) @(posedge clk);
      check(response_cycles, resp_t[i]);
      check(idle_cycles, idle_t[i]);
      check(recon_cycles, i == 3 ? 50 : 100);
      check(mem_window_size, i[0] ? 'h3fff : 'h7ff);
      rd(REG_STATUS, {i[1], i[0], 2'b01, i[0], 2'b11}, 'h6f);
      bus(1, REG_STATUS, 0);
      rd(REG_STATUS, {i[1], i[0], 2'b01, i[0], 2'b11}, 'h6f);
    end
    start <= 1;
    @(posedge clk);
    start <= 0;
    repeat (3) @(posedge clk);
    check(led_green, 1);
    rd(REG_CONTROL, 1, 1);
    irq_event <= 1;
    for (int i = 4; i >= 0; i--) begin
      bus(1, REG_IRQ_SEL, i);
      repeat (2) @(posedge clk);
      check(irq_lines, 1 << i);
    end
    bus(1, REG_IRQ_SEL, 5);
    rd(REG_IRQ_SEL, 0, 'h7);
    check(led_green, 0);
    irq_event <= 0;
    for (int a = 8; a < 16; a++) rd(a[3:0], 0, '1);
    bus(1, REG_NODE, 0);
    repeat (3) @(posedge clk);
    check(tx_enable, 0);
    bus(1, REG_BUF_DATA, 'h55);
    rd(REG_BUF_DATA, 0, 'hff);
    bus(1, REG_NODE, node);
    repeat (3) @(posedge clk);
    check(tx_enable, 1);
    rd(REG_BUF_DATA, node, 'hff);
    repeat (5) @(posedge clk);
    give_verdict;
  end
endmodule
